// ==== hw/shift_flag_bit_ops_unit.sv ====
// APB-reached working register, status register and command port
// Assumes an APB master on pclk; debug_en comes from core logic on pclk
`timescale 1ns/10ps
`include "flag_ops_defines.svh"

module shift_flag_bit_ops_unit
    import flag_ops_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic debug_en,
    output logic [7:0] status_flags,
    output logic sleep_req,
    output logic wdt_restart,
    output logic debug_break
);

    // ****************************************
    // Decoding
    // ****************************************
    function automatic logic reg_hit(input logic [11:0] a);
        return (a == `OFS_WORK) || (a == `OFS_STATUS) || (a == `OFS_CMD);
    endfunction

    function automatic logic [7:0] read_mux(input logic [11:0] a, input unit_state_type s);
        logic [7:0] d;
        d = 8'h00;
        if (a == `OFS_WORK) begin
            d = s.work;
        end else if (a == `OFS_STATUS) begin
            d = s.status;
        end else if (a == `OFS_CMD) begin
            d = s.cmd;
        end
        return d;
    endfunction

    // ****************************************
    // State and execution
    // ****************************************
    unit_state_type state_ff;
    unit_state_type nxt_state;
    logic setup_w;
    logic access_w;
    logic cmd_w;
    op_type op_w;
    logic [2:0] bit_w;
    logic [7:0] ex_work;
    logic [7:0] ex_status;

    assign setup_w = psel && penable && !state_ff.pready;
    assign access_w = psel && penable && state_ff.pready;
    assign cmd_w = access_w && pwrite && (paddr == `OFS_CMD);
    assign op_w = op_type'(pwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
    assign bit_w = pwdata[`CMD_BIT_MSB:`CMD_BIT_LSB];

    op_exec exec_u (
        .op(op_w),
        .bit_sel(bit_w),
        .work(state_ff.work),
        .status(state_ff.status),
        .nxt_work(ex_work),
        .nxt_status(ex_status)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_state.sleep_req = 1'b0;
        nxt_state.wdt_restart = 1'b0;
        nxt_state.debug_break = 1'b0;
        nxt_state.pready = setup_w;
        nxt_state.pslverr = setup_w && !reg_hit(paddr);
        if (setup_w) begin
            nxt_state.rdata = read_mux(paddr, state_ff);
        end
        if (access_w && pwrite) begin
            if (paddr == `OFS_WORK) begin
                nxt_state.work = pwdata[7:0];
            end else if (paddr == `OFS_STATUS) begin
                nxt_state.status = pwdata[7:0];
            end else if (cmd_w) begin
                nxt_state.work = ex_work; // [RQ1] [RQ2] [RQ3] [RQ10]
                nxt_state.status = ex_status; // [RQ4] [RQ5] [RQ6] [RQ11]
                nxt_state.cmd = {bit_w, op_w};
                nxt_state.sleep_req = (op_w == sleep_op); // [RQ7]
                nxt_state.wdt_restart = (op_w == watchdog_restart_op); // [RQ8]
                nxt_state.debug_break = (op_w == debug_break_op) && debug_en; // [RQ9]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '{work: `RST_WORK, status: `RST_STATUS, cmd: `RST_CMD,
                          rdata: 8'h00, default: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata = {24'h0000_00, state_ff.rdata};
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign status_flags = state_ff.status;
    assign sleep_req = state_ff.sleep_req;
    assign wdt_restart = state_ff.wdt_restart;
    assign debug_break = state_ff.debug_break;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apb_wait;
        psel && penable && !pready;
    endsequence

    sequence cmd_taken(op_type o);
        cmd_w && op_w == o;
    endsequence

    ror_result_a: assert property (cmd_taken(rotate_right_carry_op) |=> // [RQ1]
        state_ff.work == {$past(state_ff.status[`FLAG_C]), $past(state_ff.work[7:1])}
        && state_ff.status[`FLAG_C] == $past(state_ff.work[0])
        && state_ff.status[`FLAG_V] == (state_ff.work[7] ^ state_ff.status[`FLAG_C]))
        else $error("rotate right result wrong");
    asr_result_a: assert property (cmd_taken(arith_shift_right_op) |=> // [RQ2]
        state_ff.work[7] == $past(state_ff.work[7])
        && state_ff.work[6:0] == $past(state_ff.work[7:1])
        && state_ff.status[`FLAG_Z] == (state_ff.work == 8'h00))
        else $error("arithmetic shift result wrong");
    bit_store_a: assert property (cmd_taken(bit_to_transfer_op) |=> // [RQ3]
        state_ff.status[`FLAG_T] == $past(state_ff.work[bit_w])
        && state_ff.work == $past(state_ff.work))
        else $error("bit store wrong");
    ovf_only_a: assert property (cmd_taken(overflow_flag_set_op) |=> // [RQ4]
        state_ff.status == ($past(state_ff.status) | 8'h08))
        else $error("overflow set touched other bits");
    sign_only_a: assert property (cmd_taken(sign_flag_clear_op) |=> // [RQ5]
        state_ff.status == ($past(state_ff.status) & 8'hef))
        else $error("sign clear touched other bits");
    half_only_a: assert property (cmd_taken(half_carry_clear_op) |=> // [RQ6]
        state_ff.status == ($past(state_ff.status) & 8'hdf))
        else $error("half carry clear touched other bits");
    sleep_pulse_a: assert property (cmd_taken(sleep_op) |=> // [RQ7]
        sleep_req && $stable(state_ff.status) ##1 !sleep_req)
        else $error("sleep request not one cycle");
    wdt_pulse_a: assert property (cmd_taken(watchdog_restart_op) |=> // [RQ8]
        wdt_restart && $stable(state_ff.status) ##1 !wdt_restart)
        else $error("watchdog restart not one cycle");
    break_gate_a: assert property (debug_break |-> // [RQ9]
        $past(cmd_w) && $past(debug_en) && $past(op_w) == debug_break_op
        && $stable(state_ff.status))
        else $error("break without debug enable");
    swap_keep_a: assert property (cmd_taken(nibble_swap_op) |=> // [RQ10]
        state_ff.work == {$past(state_ff.work[3:0]), $past(state_ff.work[7:4])}
        && $stable(state_ff.status))
        else $error("nibble swap wrong");
    irq_only_a: assert property (cmd_taken(global_irq_enable_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) | 8'h80))
        else $error("interrupt enable touched other bits");
    apb_wait_a: assert property (apb_wait |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    // ****************************************
    // Bit load, flag-only, pulse-cause and bus checks
    // ****************************************
    function automatic logic [7:0] one_hot(input logic [2:0] pos);
        return 8'h01 << pos;
    endfunction

    sequence apb_access;
        psel && penable && pready;
    endsequence

    bit_load_a: assert property (cmd_taken(transfer_to_bit_op) |=> // [RQ3]
        state_ff.work[$past(bit_w)] == $past(state_ff.status[`FLAG_T])
        && (state_ff.work & ~one_hot($past(bit_w))) == ($past(state_ff.work) & ~one_hot($past(bit_w)))
        && $stable(state_ff.status))
        else $error("bit load wrong");
    ovf_clear_a: assert property (cmd_taken(overflow_flag_clear_op) |=> // [RQ4]
        state_ff.status == ($past(state_ff.status) & ~one_hot(3'(`FLAG_V))))
        else $error("overflow clear touched other bits");
    sign_set_a: assert property (cmd_taken(sign_flag_set_op) |=> // [RQ5]
        state_ff.status == ($past(state_ff.status) | one_hot(3'(`FLAG_S))))
        else $error("sign set touched other bits");
    half_set_a: assert property (cmd_taken(half_carry_set_op) |=> // [RQ6]
        state_ff.status == ($past(state_ff.status) | one_hot(3'(`FLAG_H))))
        else $error("half carry set touched other bits");
    carry_set_a: assert property (cmd_taken(carry_set_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) | one_hot(3'(`FLAG_C))))
        else $error("carry set touched other bits");
    carry_clear_a: assert property (cmd_taken(carry_clear_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) & ~one_hot(3'(`FLAG_C))))
        else $error("carry clear touched other bits");
    zero_set_a: assert property (cmd_taken(zero_flag_set_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) | one_hot(3'(`FLAG_Z))))
        else $error("zero set touched other bits");
    zero_clear_a: assert property (cmd_taken(zero_flag_clear_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) & ~one_hot(3'(`FLAG_Z))))
        else $error("zero clear touched other bits");
    neg_set_a: assert property (cmd_taken(negative_set_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) | one_hot(3'(`FLAG_N))))
        else $error("negative set touched other bits");
    neg_clear_a: assert property (cmd_taken(negative_clear_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) & ~one_hot(3'(`FLAG_N))))
        else $error("negative clear touched other bits");
    t_set_a: assert property (cmd_taken(transfer_flag_set_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) | one_hot(3'(`FLAG_T))))
        else $error("transfer set touched other bits");
    t_clear_a: assert property (cmd_taken(transfer_flag_clear_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) & ~one_hot(3'(`FLAG_T))))
        else $error("transfer clear touched other bits");
    irq_clear_a: assert property (cmd_taken(global_irq_disable_op) |=> // [RQ11]
        state_ff.status == ($past(state_ff.status) & ~one_hot(3'(`FLAG_I))))
        else $error("interrupt disable touched other bits");
    nop_keep_a: assert property (cmd_taken(nop_op) |=>
        $stable(state_ff.work) && $stable(state_ff.status) && !sleep_req && !wdt_restart)
        else $error("no-op changed state");
    sleep_cause_a: assert property (sleep_req |-> // [RQ7]
        $past(cmd_w) && $past(op_w) == sleep_op)
        else $error("sleep request without command");
    wdt_cause_a: assert property (wdt_restart |-> // [RQ8]
        $past(cmd_w) && $past(op_w) == watchdog_restart_op)
        else $error("watchdog restart without command");
    cmd_record_a: assert property (apb_access ##0 (pwrite && paddr == `OFS_CMD) |=>
        state_ff.cmd == $past({bit_w, op_w}))
        else $error("command not recorded");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error outside the answer cycle");

endmodule

// ==== hw/flag_ops_defines.svh ====
// Register offsets, field positions and reset values of the flag/shift unit
// Assumes an APB slave with 12-bit byte addresses and 32-bit data
// How it works
// [RQ1] Rotate right: carry into bit 7, bit 0 into carry; Z,C,N,V set; one cycle.
// [RQ2] Arithmetic right shift keeps bit 7; Z,C,N,V set; one cycle.
// [RQ3] Bit store copies register bit to T; bit load copies T back.
// [RQ4] Overflow flag set and clear touch only V, one cycle each.
// [RQ5] Sign flag set and clear touch only S, one cycle each.
// [RQ6] Half carry set and clear touch only H; clear takes one cycle.
// [RQ7] Sleep takes one cycle, keeps flags, raises a sleep request.
// [RQ8] Watchdog restart takes one cycle, keeps flags, pulses restart.
// [RQ9] Break keeps flags and acts only while debugging is enabled.
// [RQ10] Nibble exchange swaps register halves in one cycle, flags kept.
// [RQ11] Set and clear of C, N, Z, T and I touch only their own bit.
`ifndef FLAG_OPS_DEFINES_SVH
`define FLAG_OPS_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define OFS_WORK 12'h000
`define OFS_STATUS 12'h004
`define OFS_CMD 12'h008

// ****************************************
// Fields
// ****************************************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
`define CMD_OP_MSB 4
`define CMD_OP_LSB 0
`define CMD_BIT_MSB 10
`define CMD_BIT_LSB 8
`define BYTE_MSB 7

// ****************************************
// Reset values
// ****************************************
`define RST_WORK 8'h00
`define RST_STATUS 8'h00
`define RST_CMD 8'h00

`endif

// ==== hw/flag_ops_pkg.sv ====
// Types of the flag/shift unit
// Assumes flag_ops_defines.svh for the numbers
package flag_ops_pkg;

    // ****************************************
    // Operation codes
    // ****************************************
    typedef enum logic [4:0] {
        nop_op = 5'h00,
        rotate_right_carry_op = 5'h01,
        arith_shift_right_op = 5'h02,
        nibble_swap_op = 5'h03,
        bit_to_transfer_op = 5'h04,
        transfer_to_bit_op = 5'h05,
        status_bit_set_op = 5'h06,
        status_bit_clear_op = 5'h07,
        sleep_op = 5'h08,
        watchdog_restart_op = 5'h09,
        debug_break_op = 5'h0a,
        carry_set_op = 5'h10,
        carry_clear_op = 5'h11,
        zero_flag_set_op = 5'h12,
        zero_flag_clear_op = 5'h13,
        negative_set_op = 5'h14,
        negative_clear_op = 5'h15,
        overflow_flag_set_op = 5'h16,
        overflow_flag_clear_op = 5'h17,
        sign_flag_set_op = 5'h18,
        sign_flag_clear_op = 5'h19,
        half_carry_set_op = 5'h1a,
        half_carry_clear_op = 5'h1b,
        transfer_flag_set_op = 5'h1c,
        transfer_flag_clear_op = 5'h1d,
        global_irq_enable_op = 5'h1e,
        global_irq_disable_op = 5'h1f
    } op_type;

    // ****************************************
    // Unit state
    // ****************************************
    typedef struct packed {
        logic [7:0] work;
        logic [7:0] status;
        logic [7:0] cmd;
        logic [7:0] rdata;
        logic pready;
        logic pslverr;
        logic sleep_req;
        logic wdt_restart;
        logic debug_break;
    } unit_state_type;

endpackage

// ==== hw/op_exec.sv ====
// Combinational execution of one shift, bit or flag operation
// Assumes the caller registers the results in the same cycle
`timescale 1ns/10ps
`include "flag_ops_defines.svh"

module op_exec
    import flag_ops_pkg::*;
(
    input wire op_type op,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] work,
    input wire logic [7:0] status,
    output logic [7:0] nxt_work,
    output logic [7:0] nxt_status
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [2:0] flag_pos(input op_type o);
        logic [2:0] p;
        p = 3'(`FLAG_C);
        unique case (o[3:1])
            3'h0: p = 3'(`FLAG_C);
            3'h1: p = 3'(`FLAG_Z);
            3'h2: p = 3'(`FLAG_N);
            3'h3: p = 3'(`FLAG_V);
            3'h4: p = 3'(`FLAG_S);
            3'h5: p = 3'(`FLAG_H);
            3'h6: p = 3'(`FLAG_T);
            3'h7: p = 3'(`FLAG_I);
        endcase
        return p;
    endfunction

    function automatic logic [7:0] shift_flags(input logic [7:0] st, input logic [7:0] res,
                                               input logic c);
        logic [7:0] s;
        s = st;
        s[`FLAG_C] = c;
        s[`FLAG_Z] = (res == 8'h00);
        s[`FLAG_N] = res[`BYTE_MSB];
        s[`FLAG_V] = res[`BYTE_MSB] ^ c;
        return s;
    endfunction

    // ****************************************
    // Execute
    // ****************************************
    always_comb begin
        nxt_work = work;
        nxt_status = status;
        case (op)
            rotate_right_carry_op: begin
                nxt_work = {status[`FLAG_C], work[7:1]}; // [RQ1]
                nxt_status = shift_flags(status, nxt_work, work[0]); // [RQ1]
            end
            arith_shift_right_op: begin
                nxt_work = {work[`BYTE_MSB], work[7:1]}; // [RQ2]
                nxt_status = shift_flags(status, nxt_work, work[0]); // [RQ2]
            end
            nibble_swap_op: nxt_work = {work[3:0], work[7:4]}; // [RQ10]
            bit_to_transfer_op: nxt_status[`FLAG_T] = work[bit_sel]; // [RQ3]
            transfer_to_bit_op: nxt_work[bit_sel] = status[`FLAG_T]; // [RQ3]
            status_bit_set_op: nxt_status[bit_sel] = 1'b1;
            status_bit_clear_op: nxt_status[bit_sel] = 1'b0;
            carry_set_op, zero_flag_set_op, negative_set_op, overflow_flag_set_op,
            sign_flag_set_op, half_carry_set_op, transfer_flag_set_op,
            global_irq_enable_op: nxt_status[flag_pos(op)] = 1'b1; // [RQ4] [RQ5] [RQ6] [RQ11]
            carry_clear_op, zero_flag_clear_op, negative_clear_op, overflow_flag_clear_op,
            sign_flag_clear_op, half_carry_clear_op, transfer_flag_clear_op,
            global_irq_disable_op: nxt_status[flag_pos(op)] = 1'b0; // [RQ4] [RQ5] [RQ6] [RQ11]
            default: begin
                nxt_work = work; // [RQ7] [RQ8] [RQ9]
                nxt_status = status;
            end
        endcase
    end

endmodule

// ==== sim/shift_flag_bit_ops_unit_test.sv ====
// Self-checking bench for the shift, bit and flag operation unit
// Assumes the unit is reached over APB on pclk; the bench drives every port itself
`timescale 1ns/10ps
`include "flag_ops_defines.svh"

module shift_flag_bit_ops_unit_test
    import flag_ops_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic debug_en;
    logic [7:0] status_flags;
    logic sleep_req;
    logic wdt_restart;
    logic debug_break;
    int n_fail;
    int compares;
    logic [31:0] rd;
    logic err;
    logic [2:0] p1;
    logic [2:0] p2;
    logic [7:0] flags_seen;

    shift_flag_bit_ops_unit i_shift_flag_bit_ops_unit (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_en(debug_en),
        .status_flags(status_flags), .sleep_req(sleep_req),
        .wdt_restart(wdt_restart), .debug_break(debug_break)
    );

    always #20 pclk = ~pclk;

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Bus transfer
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic dbg);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        debug_en <= dbg;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) begin
            check("pready", 32'd0, 32'd1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        p1 = {debug_break, wdt_restart, sleep_req};
        flags_seen = status_flags;
        @(posedge pclk);
        #1;
        p2 = {debug_break, wdt_restart, sleep_req};
    endtask

    // ****************************************
    // Expected result of one command
    // ****************************************
    function automatic logic [15:0] model(input logic [4:0] op, input logic [2:0] b,
                                          input logic [7:0] w, input logic [7:0] s);
        logic [7:0] r;
        logic [7:0] f;
        r = w;
        f = s;
        case (op)
            5'h01, 5'h02: begin
                r = {(op == 5'h01) ? s[`FLAG_C] : w[7], w[7:1]};
                f[`FLAG_C] = w[0];
                f[`FLAG_Z] = (r == 8'h00);
                f[`FLAG_N] = r[7];
                f[`FLAG_V] = r[7] ^ w[0];
            end
            5'h03: r = {w[3:0], w[7:4]};
            5'h04: f[`FLAG_T] = w[b];
            5'h05: r[b] = s[`FLAG_T];
            5'h06: f[b] = 1'b1;
            5'h07: f[b] = 1'b0;
            default: if (op[4]) f[op[3:1]] = ~op[0];
        endcase
        return {r, f};
    endfunction

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        logic [7:0] w;
        logic [7:0] s;
        logic [2:0] b;
        logic dbg;
        logic [15:0] exp;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        debug_en = 1'b0;
        n_fail = 0;
        compares = 0;
        void'($urandom(32'h73cf8337));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check("flags after reset", {24'h0, status_flags}, 32'h0000_0000);
        check("prdata after reset", prdata, 32'h0000_0000);
        check("answer after reset", {30'h0, pready, pslverr}, 32'h0000_0000);
        apb(1'b0, `OFS_WORK, 32'h0000_0000, 1'b0);
        check("work reset", rd, 32'h0000_0000);
        apb(1'b0, `OFS_CMD, 32'h0000_0000, 1'b0);
        check("cmd reset", rd, 32'h0000_0000);
        $display("Reset test done");
        apb(1'b1, `OFS_WORK, 32'h0000_005a, 1'b0);
        apb(1'b1, 12'h010, 32'h0000_00ff, 1'b0);
        check("write error", {31'h0, err}, 32'h0000_0001);
        apb(1'b0, 12'hffc, 32'h0000_0000, 1'b0);
        check("read error", {31'h0, err}, 32'h0000_0001);
        check("read error data", rd, 32'h0000_0000);
        apb(1'b0, `OFS_WORK, 32'h0000_0000, 1'b0);
        check("work kept", rd, 32'h0000_005a);
        check("mapped no error", {31'h0, err}, 32'h0000_0000);
        $display("Unmapped address test done");
        for (int pass = 0; pass < 4; pass++) begin
            for (int c = 0; c < 32; c++) begin
                w = 8'($urandom);
                s = 8'($urandom);
                b = 3'($urandom);
                dbg = 1'($urandom);
                if (pass == 0) begin
                    w = 8'h01;
                    s = 8'h00;
                end else if (pass == 1) begin
                    w = 8'h80;
                    s = 8'hff;
                end
                apb(1'b1, `OFS_WORK, {24'h0, w}, dbg);
                apb(1'b1, `OFS_STATUS, {24'h0, s}, dbg);
                apb(1'b1, `OFS_CMD, {21'h0, b, 3'h0, 5'(c)}, dbg);
                exp = model(5'(c), b, w, s);
                check("flags out", {24'h0, flags_seen}, {24'h0, exp[7:0]});
                check("sleep pulse", {31'h0, p1[0]}, {31'h0, c == 8});
                check("restart pulse", {31'h0, p1[1]}, {31'h0, c == 9});
                check("break pulse", {31'h0, p1[2]}, {31'h0, c == 10 && dbg});
                check("pulse width", {29'h0, p2}, 32'h0000_0000);
                apb(1'b0, `OFS_WORK, 32'h0000_0000, dbg);
                check("work", rd, {24'h0, exp[15:8]});
                apb(1'b0, `OFS_STATUS, 32'h0000_0000, dbg);
                check("status", rd, {24'h0, exp[7:0]});
                apb(1'b0, `OFS_CMD, 32'h0000_0000, dbg);
                check("cmd", rd, {24'h0, b, 5'(c)});
            end
            $display("Operation pass %0d done", pass);
        end
        tally_and_finish();
    end

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        #(40 * 20000);
        n_fail++;
        tally_and_finish();
    end
endmodule
